//--- src/access_window_timer.sv
`timescale 1ns/1ps
module access_window_timer #(
	parameter int WINDOW = bus_fault_pkg::WINDOW_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic stop_i,
	output logic busy_o,
	output logic expire_o
);
	import bus_fault_pkg::*;

	localparam int CNT_W = $clog2(WINDOW + 1);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(WINDOW - 1);

	typedef struct packed {
		logic busy;
		logic [CNT_W-1:0] cnt;
	} timer_t;

	timer_t s;
	timer_t next_s;

	assign busy_o = s.busy;
	// the cycle that a response may still arrive in is not counted as lost
	assign expire_o = s.busy && !stop_i && (s.cnt == LAST);

	always_comb begin
		next_s = s;
		if (start_i) begin
			// a new request restarts the window
			next_s.busy = 1'b1;
			next_s.cnt = '0;
		end else if (s.busy) begin
			if (stop_i || expire_o) begin
				next_s.busy = 1'b0;
			end else begin
				next_s.cnt = s.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule

//--- src/bus_fault_monitor.sv
// Notes on behaviour
// - watch every CPU transaction; fault on device error or missing answer
// - fault kind follows access: fetch, store or load
// - answer window is a build constant, 15 cycles by default
// - status bit 31 is set on a fault and stays set
// - any read or write of status clears the sticky flag
// - status bit 0: 0 for device error, 1 for timeout
// - cause bit is read-only, valid only while the flag is set
// - external interface timeout is recorded with the timeout cause
// - protection faults raise the exception but leave the flag clear
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
module bus_fault_monitor #(
	parameter int WINDOW = bus_fault_pkg::WINDOW_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [bus_fault_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [bus_fault_pkg::SEL_W-1:0] wb_sel_i,
	input wire logic [bus_fault_pkg::DATA_W-1:0] wb_dat_i,
	output logic [bus_fault_pkg::DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic bus_req_i,
	input wire logic bus_we_i,
	input wire logic bus_fetch_i,
	input wire logic bus_ack_i,
	input wire logic bus_err_i,
	input wire logic ext_timeout_i,
	input wire logic cpu_memory_protection_fault_i,
	output logic fetch_fault_o,
	output logic load_fault_o,
	output logic store_fault_o,
	output logic irq_o
);
	import bus_fault_pkg::*;

	typedef struct packed {
		kind_t kind;
		logic flag;
		logic cause;
		logic mask;
		logic fetch_fault;
		logic load_fault;
		logic store_fault;
		logic irq;
		logic [DATA_W-1:0] rdata;
	} mon_t;

	mon_t s;
	mon_t next_s;

	logic busy;
	logic expire;
	logic stop;
	logic take;
	logic hit_status;
	logic hit_mask;
	logic dev_fault;
	logic fault_any;
	logic fault_cause;
	kind_t raise_kind;
	logic raise;

	// an ack, an error or the external timeout all end the transaction
	assign stop = bus_ack_i || bus_err_i || ext_timeout_i;

	access_window_timer #(
		.WINDOW(WINDOW)
	) u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(bus_req_i),
		.stop_i(stop),
		.busy_o(busy),
		.expire_o(expire)
	);

	wb_reg_port u_port (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(wb_cyc_i),
		.stb_i(wb_stb_i),
		.adr_i(wb_adr_i),
		.ack_o(wb_ack_o),
		.take_o(take),
		.hit_status_o(hit_status),
		.hit_mask_o(hit_mask)
	);

	assign wb_dat_o = s.rdata;
	assign fetch_fault_o = s.fetch_fault;
	assign load_fault_o = s.load_fault;
	assign store_fault_o = s.store_fault;
	assign irq_o = s.irq;

	// responses outside a tracked transaction are ignored
	assign dev_fault = busy && bus_err_i;
	assign fault_any = dev_fault || expire || (busy && ext_timeout_i);
	// a device error reported together with a timeout names the device
	assign fault_cause = dev_fault ? CAUSE_DEVICE : CAUSE_TIMEOUT;

	always_comb begin
		raise = 1'b0;
		raise_kind = s.kind;
		if (fault_any) begin
			raise = 1'b1;
			raise_kind = s.kind;
		end else if (cpu_memory_protection_fault_i) begin
			// blocked access never reaches the bus, so its kind comes from the request
			raise = 1'b1;
			raise_kind = kind_of(bus_we_i, bus_fetch_i);
		end
	end

	always_comb begin
		next_s = s;
		next_s.fetch_fault = raise && (raise_kind == KIND_FETCH);
		next_s.load_fault = raise && (raise_kind == KIND_LOAD);
		next_s.store_fault = raise && (raise_kind == KIND_STORE);
		if (bus_req_i) begin
			next_s.kind = kind_of(bus_we_i, bus_fetch_i);
		end
		if (take) begin
			next_s.rdata = DATA_RESET;
			if (hit_status) begin
				next_s.rdata[FLAG_BIT] = s.flag;
				next_s.rdata[CAUSE_BIT] = s.cause;
				next_s.flag = 1'b0;
			end else if (hit_mask) begin
				next_s.rdata[FLAG_BIT] = s.mask;
				if (wb_we_i && wb_sel_i[FLAG_LANE]) begin
					next_s.mask = wb_dat_i[FLAG_BIT];
				end
			end
		end
		// set wins over the access clear so no fault is lost
		if (fault_any) begin
			next_s.flag = 1'b1;
			next_s.cause = fault_cause;
		end
		next_s.irq = next_s.flag && next_s.mask;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.kind <= KIND_FETCH;
			s.flag <= FLAG_RESET;
			s.cause <= CAUSE_RESET;
			s.mask <= MASK_RESET;
			s.rdata <= DATA_RESET;
		end else begin
			s <= next_s;
		end
	end

	// checking: helper counts quiet cycles of the tracked transaction
	localparam logic [7:0] QUIET_LAST = 8'(WINDOW - 1);
	logic [7:0] quiet;
	logic quiet_step;

	assign quiet_step = busy && !stop && !bus_req_i;

	always_ff @(posedge clk_i) begin
		if (rst_i || bus_req_i) begin
			quiet <= '0;
		end else if (quiet_step && quiet != 8'hff) begin
			quiet <= quiet + 8'h01;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_dev_err;
		busy && bus_err_i;
	endsequence

	sequence s_any_fault_out;
		fetch_fault_o || load_fault_o || store_fault_o;
	endsequence

	sequence s_status_access;
		take && hit_status;
	endsequence

	property p_err_faults;
		s_dev_err |=> s_any_fault_out;
	endproperty
	a_err_faults: assert property (p_err_faults) else $error("device error raised no fault");

	property p_store_kind;
		s_dev_err ##0 (s.kind == KIND_STORE) |=> store_fault_o && !load_fault_o && !fetch_fault_o;
	endproperty
	a_store_kind: assert property (p_store_kind) else $error("store fault kind wrong");

	property p_fetch_kind;
		bus_req_i && bus_fetch_i ##1 (!bus_req_i && busy && bus_err_i) |=> fetch_fault_o;
	endproperty
	a_fetch_kind: assert property (p_fetch_kind) else $error("fetch fault kind wrong");

	property p_window_expire;
		quiet_step && quiet == QUIET_LAST |=> s.flag && s.cause == CAUSE_TIMEOUT && !busy;
	endproperty
	a_window_expire: assert property (p_window_expire) else $error("timeout not at window end");

	property p_window_early;
		quiet_step && quiet < QUIET_LAST && !cpu_memory_protection_fault_i
			|=> not s_any_fault_out;
	endproperty
	a_window_early: assert property (p_window_early) else $error("timeout raised too early");

	property p_flag_sticky;
		s.flag && !(take && hit_status) |=> s.flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("sticky flag dropped");

	property p_access_clears;
		take && hit_status && !fault_any |=> !s.flag ##0 wb_ack_o;
	endproperty
	a_access_clears: assert property (p_access_clears) else $error("status access kept flag");

	property p_dev_cause;
		s_dev_err |=> s.flag && s.cause == CAUSE_DEVICE;
	endproperty
	a_dev_cause: assert property (p_dev_cause) else $error("device error cause wrong");

	property p_cause_held;
		!fault_any |=> $stable(s.cause);
	endproperty
	a_cause_held: assert property (p_cause_held) else $error("cause changed without fault");

	property p_ext_timeout;
		busy && ext_timeout_i && !bus_err_i |=> s.flag && s.cause == CAUSE_TIMEOUT;
	endproperty
	a_ext_timeout: assert property (p_ext_timeout) else $error("external timeout not recorded");

	property p_protect_no_flag;
		cpu_memory_protection_fault_i && !fault_any && !s.flag |=> !s.flag and s_any_fault_out;
	endproperty
	a_protect_no_flag: assert property (p_protect_no_flag) else $error("protection fault set flag");

	property p_ack_ends;
		// a fresh request right after the ack may legally restart the window
		busy && bus_ack_i && !bus_err_i && !bus_req_i |=> !busy ##1 (!busy || $past(bus_req_i));
	endproperty
	a_ack_ends: assert property (p_ack_ends) else $error("transaction not ended by ack");

	property p_reserved_zero;
		wb_ack_o |-> wb_dat_o[FLAG_BIT-1:CAUSE_BIT+1] == '0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

	property p_irq_follows;
		s.flag && s.mask |-> irq_o;
	endproperty
	a_irq_follows: assert property (p_irq_follows) else $error("interrupt not raised");

	property p_load_kind;
		s_dev_err ##0 (s.kind == KIND_LOAD) |=> load_fault_o && !store_fault_o && !fetch_fault_o;
	endproperty
	a_load_kind: assert property (p_load_kind) else $error("load fault kind wrong");

	property p_fault_onehot;
		$onehot0({fetch_fault_o, load_fault_o, store_fault_o});
	endproperty
	a_fault_onehot: assert property (p_fault_onehot) else $error("fault kinds overlap");

	property p_idle_quiet;
		!busy && !cpu_memory_protection_fault_i |=> not s_any_fault_out;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("fault with no transaction");

	property p_wb_answer;
		take |=> wb_ack_o;
	endproperty
	a_wb_answer: assert property (p_wb_answer) else $error("register access not acked");

	property p_wb_ack_once;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_wb_ack_once: assert property (p_wb_ack_once) else $error("ack longer than one cycle");

	property p_status_data;
		s_status_access |=> wb_dat_o[FLAG_BIT] == $past(s.flag)
			&& wb_dat_o[CAUSE_BIT] == $past(s.cause);
	endproperty
	a_status_data: assert property (p_status_data) else $error("status read data wrong");

	property p_irq_clear;
		s_status_access ##0 !fault_any |=> !irq_o;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("irq kept after clear");

	property p_mask_write;
		take && hit_mask && wb_we_i && wb_sel_i[FLAG_LANE]
			|=> s.mask == $past(wb_dat_i[FLAG_BIT]);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write lost");

	property p_protect_kind;
		cpu_memory_protection_fault_i && bus_we_i && !bus_fetch_i && !fault_any
			|=> store_fault_o;
	endproperty
	a_protect_kind: assert property (p_protect_kind) else $error("protect kind wrong");

endmodule

//--- src/bus_fault_pkg.sv
package bus_fault_pkg;

	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int SEL_W = 4;

	// register map, byte addresses
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 32'hffffff7c;
	localparam logic [ADDR_W-1:0] MASK_ADDR = 32'hffffff78;

	// field positions, shared by status and mask
	localparam int FLAG_BIT = 31;
	localparam int CAUSE_BIT = 0;
	localparam int FLAG_LANE = 3;

	// cause encodings
	localparam logic CAUSE_DEVICE = 1'b0;
	localparam logic CAUSE_TIMEOUT = 1'b1;

	// reset values
	localparam logic FLAG_RESET = 1'b0;
	localparam logic CAUSE_RESET = 1'b0;
	localparam logic MASK_RESET = 1'b0;
	localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;

	// access window in clock cycles
	localparam int WINDOW_CYCLES = 15;

	typedef enum logic [1:0] {
		KIND_FETCH,
		KIND_LOAD,
		KIND_STORE
	} kind_t;

	function automatic kind_t kind_of(input logic we, input logic fetch);
		if (fetch) begin
			return KIND_FETCH;
		end
		return we ? KIND_STORE : KIND_LOAD;
	endfunction

	function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
		return a[ADDR_W-1:2] == b[ADDR_W-1:2];
	endfunction

endpackage

//--- src/wb_reg_port.sv
`timescale 1ns/1ps
module wb_reg_port (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic [bus_fault_pkg::ADDR_W-1:0] adr_i,
	output logic ack_o,
	output logic take_o,
	output logic hit_status_o,
	output logic hit_mask_o
);
	import bus_fault_pkg::*;

	typedef struct packed {
		logic ack;
	} port_t;

	port_t s;
	port_t next_s;

	assign ack_o = s.ack;
	// one answer per request: ack drops the cycle after it was given
	assign take_o = cyc_i && stb_i && !s.ack;
	assign hit_status_o = addr_hit(adr_i, STATUS_ADDR);
	assign hit_mask_o = addr_hit(adr_i, MASK_ADDR);

	always_comb begin
		next_s = s;
		next_s.ack = take_o;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule

//--- test/bus_device_model.sv
`timescale 1ns/1ps
module bus_device_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_i,
	input wire logic [1:0] mode_i,
	input wire logic [3:0] delay_i,
	output logic ack_o,
	output logic err_o
);
	logic [3:0] cnt;
	logic [1:0] mode;
	// a new request drops the old one, as the cpu side does
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= 4'h0;
			mode <= 2'h0;
		end else if (req_i) begin
			cnt <= delay_i;
			mode <= mode_i;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
	end
	// mode 0 acks, 1 errors, 2 stays silent
	assign ack_o = (cnt == 4'h1) && (mode == 2'h0);
	assign err_o = (cnt == 4'h1) && (mode == 2'h1);
endmodule

//--- test/bus_fault_monitor_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module bus_fault_monitor_test;
	import bus_fault_pkg::*;
	localparam int W = 4;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, req = 0, bwe = 0, fet = 0;
	logic ext = 0, prot = 0, ack, dack, derr, ff, lf, sf, irq;
	logic [31:0] adr = 0, wd = 0, rd;
	logic [3:0] sel = 0, dly = 0;
	logic [1:0] md = 0;
	int errors = 0, n_checks = 0, eflag = 0, ecause = 0, emask = 0, ecnt = 0, redge, fedge;
	int obs[$], exq[$];
	initial forever #12.5 clk_i = ~clk_i;
	bus_fault_monitor #(.WINDOW(W)) bus_fault_monitor_i (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .bus_req_i(req), .bus_we_i(bwe),
		.bus_fetch_i(fet), .bus_ack_i(dack), .bus_err_i(derr), .ext_timeout_i(ext),
		.cpu_memory_protection_fault_i(prot), .fetch_fault_o(ff), .load_fault_o(lf),
		.store_fault_o(sf), .irq_o(irq));
	bus_device_model bus_device_model_i (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
		.mode_i(md), .delay_i(dly), .ack_o(dack), .err_o(derr));
	// one process keeps edge count and pulses in step
	always @(posedge clk_i) begin
		ecnt++;
		if (req === 1'b1) redge = ecnt;
		if ((ff | lf | sf) === 1'b1) begin
			fedge = ecnt;
			obs.push_back(ff ? 0 : lf ? 1 : 2);
		end
	end
	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wd <= d; sel <= 4'hf;
		// no cycle count assumed: only the watchdog ends a missing ack
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rd;
		cyc <= 1'b0; stb <= 1'b0;
	endtask
	task automatic rd_st();
		logic [31:0] q;
		`CHK(irq, 1'(eflag & emask))
		wb(1'b0, STATUS_ADDR, 32'h0, q);
		`CHK(q[31], 1'(eflag))
		if (eflag) `CHK(q[0], 1'(ecause))
		`CHK(q[30:1], 30'h0)
		eflag = 0;
	endtask
	// kind 0 fetch, 1 load, 2 store
	task automatic txn(input int k, input int m, input int d, input bit x, input bit p);
		@(posedge clk_i);
		req <= !p; prot <= p; fet <= (k == 0); bwe <= (k == 2); md <= 2'(m); dly <= 4'(d);
		@(posedge clk_i);
		req <= 1'b0; prot <= 1'b0;
		if (x) begin
			repeat (d - 1) @(posedge clk_i);
			ext <= 1'b1;
			@(posedge clk_i);
			ext <= 1'b0;
		end
		repeat (W + 3) @(posedge clk_i);
		if (p || m > 0 || x) exq.push_back(k);
		if (!p && (m > 0 || x)) begin
			eflag = 1;
			ecause = (m == 1) ? 0 : 1;
		end
		`CHK(obs.size(), exq.size())
		foreach (exq[i]) if (i < obs.size()) `CHK(obs[i], exq[i])
		exq.delete();
		obs.delete();
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (4000) @(posedge clk_i);
		$display("[ERR] %0t watchdog expired", $time);
		errors++;
		wrap_up();
	end
	initial begin
		logic [31:0] q;
		int d;
		void'($urandom(33));
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_st();
		wb(1'b0, MASK_ADDR, 32'h0, q);
		`CHK(q, 32'h0)
		wb(1'b0, 32'h0000_1000, 32'h0, q);
		`CHK(q, 32'h0)
		wb(1'b1, MASK_ADDR, 32'h8000_0000, q);
		emask = 1;
		txn(1, 2, 0, 0, 0);
		`CHK(fedge - redge, W + 1)
		rd_st();
		rd_st();
		for (int k = 0; k < 3; k++) for (int m = 1; m < 3; m++) begin
			d = 1 + $urandom % (W - 1);
			txn(k, m, d, 0, 0);
			if (m == 1) `CHK(fedge - redge, d + 1)
			rd_st();
		end
		txn(2, 1, 2, 0, 0);
		repeat (W + 5) @(posedge clk_i);
		`CHK(irq, 1'b1)
		wb(1'b1, STATUS_ADDR, $urandom, q);
		eflag = 0;
		rd_st();
		txn(0, 0, W, 0, 0);
		rd_st();
		txn(0, 2, 2, 1, 0);
		rd_st();
		txn(2, 0, 1, 0, 1);
		rd_st();
		wrap_up();
	end
endmodule
